/* File: bench/t0ps_src.sv */
// Purpose: External pulse source driving the timer count pin.
// Assumes: Levels change just after a falling clock edge.
// Notes:   The pin is always driven; it rests at the last level set.
`timescale 1ns/1ps
module t0ps_src (
	// Clock.
	input  wire logic clk_sys_i,
	// Count pin.
	output logic      pin_o
);

	initial pin_o = 1'b0;

	task automatic lvl(input logic v);
		@(negedge clk_sys_i);
		pin_o = v;
	endtask

	// Each level is held four clocks, so a pulse lasts eight clocks.
	task automatic pulses(input int n);
		repeat (n) begin
			lvl(1'b1);
			repeat (3) @(negedge clk_sys_i);
			lvl(1'b0);
			repeat (3) @(negedge clk_sys_i);
		end
	endtask

endmodule

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench for the timer/counter with prescaler.
// Assumes: Count register address is held selected except when noted.
// Notes:   Rates are measured as differences, so phase does not matter.
`timescale 1ns/1ps
module tb_top;

	logic       clk_sys_i   = 1'b0;
	logic       resetn_i    = 1'b0;
	logic [6:0] addr        = 7'h01;
	logic       wr          = 1'b0;
	logic [7:0] wdat        = 8'h00;
	logic       cfg_ld      = 1'b0;
	logic       dir_ld      = 1'b0;
	logic [7:0] wreg        = 8'h00;
	logic       wdt_in      = 1'b0;
	wire  [7:0] rdata;
	wire  [5:0] oe;
	wire        wdt_out;
	wire        pin;
	int         failures    = 0;
	int         checks_done = 0;
	int         wcnt        = 0;
	int         n1;
	int         n2;
	logic [7:0] a;
	logic [7:0] b;

	always #4 clk_sys_i = ~clk_sys_i;

	always @(posedge clk_sys_i) begin
		if (wdt_out === 1'b1)
			wcnt = wcnt + 1;
	end

	t0ps_timer uut (
		.clk_sys_i              (clk_sys_i),
		.resetn_i               (resetn_i),
		.reg_addr_i             (addr),
		.reg_wr_i               (wr),
		.reg_wdata_i            (wdat),
		.reg_rdata_o            (rdata),
		.cfg_load_i             (cfg_ld),
		.dir_load_i             (dir_ld),
		.w_data_i               (wreg),
		.external_count_input_i (pin),
		.port_c_oe_o            (oe),
		.watchdog_tick_i        (wdt_in),
		.watchdog_tick_o        (wdt_out)
	);

	t0ps_src src (
		.clk_sys_i (clk_sys_i),
		.pin_o     (pin)
	);

	task automatic chk(input string nm, input logic [7:0] e,
	                   input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			failures++;
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask

	task automatic get(output logic [7:0] v);
		@(negedge clk_sys_i);
		v = rdata;
	endtask

	task automatic wr_reg(input logic [6:0] ad, input logic [7:0] d);
		@(negedge clk_sys_i);
		addr = ad;
		wdat = d;
		wr = 1'b1;
		@(negedge clk_sys_i);
		wr = 1'b0;
	endtask

	task automatic load(input logic c, input logic [7:0] d);
		@(negedge clk_sys_i);
		wreg = d;
		cfg_ld = c;
		dir_ld = ~c;
		@(negedge clk_sys_i);
		cfg_ld = 1'b0;
		dir_ld = 1'b0;
	endtask

	// Clocks until the count moves after a pin change; 12 means never.
	task automatic lat(output int n);
		logic [7:0] a0;
		logic [7:0] v;
		a0 = rdata;
		n = 0;
		do begin
			get(v);
			n++;
		end while (v === a0 && n < 12);
		if (n < 12)
			chk("ext step", a0 + 8'h01, v);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge clk_sys_i);
		failures++;
		conclude();
	end

	initial begin
		tick(20);
		resetn_i = 1'b1;
		tick(2);
		chk("oe reset", 8'h00, {2'b00, oe});
		wr_reg(7'h01, 8'h55);
		tick(20);
		get(a);
		chk("idle count", 8'h55, a);
		resetn_i = 1'b0;
		tick(3);
		resetn_i = 1'b1;
		// Wait past the first sampling strobes, where a false edge would land.
		tick(8);
		get(a);
		chk("count kept", 8'h55, a);
		load(1'b0, 8'h00);
		tick(1);
		chk("oe counter", 8'h1F, {2'b00, oe});
		load(1'b1, 8'h08);
		tick(1);
		chk("oe timer", 8'h3F, {2'b00, oe});
		$display("test reset_and_pins done");
		wr_reg(7'h01, 8'hFA);
		tick(5);
		get(a);
		chk("inhibit", 8'hFA, a);
		tick(16);
		get(a);
		tick(15);
		get(b);
		chk("rate wrap", a + 8'h04, b);
		wr_reg(7'h02, 8'h00);
		get(a);
		chk("unmapped", 8'h00, a);
		addr = 7'h01;
		$display("test timer done");
		for (int r = 0; r < 4; r++) begin
			load(1'b1, 8'h08 | r[7:0]);
			wcnt = 0;
			repeat (32) begin
				@(negedge clk_sys_i);
				wdt_in = 1'b1;
				@(negedge clk_sys_i);
				wdt_in = 1'b0;
			end
			tick(4);
			chk("wdt ratio", 8'h20 >> r, wcnt[7:0]);
		end
		$display("test watchdog done");
		for (int r = 0; r < 8; r++) begin
			load(1'b1, r[7:0]);
			tick(8);
			get(a);
			tick((16 << r) - 1);
			get(b);
			chk("timer ratio", a + 8'h02, b);
		end
		wcnt = 0;
		repeat (8) begin
			@(negedge clk_sys_i);
			wdt_in = 1'b1;
			@(negedge clk_sys_i);
			wdt_in = 1'b0;
		end
		tick(4);
		chk("wdt off", 8'h00, wcnt[7:0]);
		$display("test prescale done");
		for (int e = 0; e < 2; e++) begin
			load(1'b1, {3'b001, e[0], 4'h8});
			tick(4);
			src.lvl(1'b1);
			lat(n1);
			src.lvl(1'b0);
			lat(n2);
			chk("rise", {7'h00, ~e[0]}, {7'h00, n1 >= 3 && n1 <= 9});
			chk("fall", {7'h00, e[0]}, {7'h00, n2 >= 3 && n2 <= 9});
		end
		load(1'b1, 8'h20);
		tick(4);
		get(a);
		src.pulses(10);
		tick(12);
		get(b);
		chk("ext prescale", a + 8'h05, b);
		$display("test counter done");
		conclude();
	end

endmodule

/* File: hw/t0ps_presc.sv */
// Purpose: Eight-bit prescaler with power-of-two taps.
// Assumes: tick_i is a one-cycle pulse; clr_i restarts the division.
// Notes:   Taps are counter bits, so each output is symmetrical, except div_wdt_o at rate 0, which is held low.
`timescale 1ns/1ps
module t0ps_presc
	import t0ps_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk_sys_i,
	input  wire logic       resetn_i,
	// Control.
	input  wire logic       clr_i,
	input  wire logic       tick_i,
	input  wire logic [2:0] rate_i,
	// Divided levels.
	output logic            div_timer_o,
	output logic            div_wdt_o
);

	logic [7:0] cnt_q;

	// The count is internal only; no register path reads or loads it.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_q <= 8'h00;
		end else if (clr_i) begin
			cnt_q <= 8'h00;
		end else if (tick_i) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	// Timer tap divides by 2 to 256, watchdog tap by 2 to 128; rate 0 holds the watchdog tap low.
	assign div_timer_o = cnt_q[rate_i];
	assign div_wdt_o   = (rate_i == 3'h0) ? 1'b0
	                     : cnt_q[3'(rate_i - 3'h1)];

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	chk_div_step: assert property (
		tick_i && !clr_i |=> cnt_q == 8'($past(cnt_q) + 8'h01))
		else $error("prescaler did not advance on its tick");

endmodule

/* File: hw/t0ps_timer.sv */
// Purpose: Eight-bit timer/counter with a prescaler shared with watchdog.
// Assumes: Register strobes come from the core and are synchronous.
// Notes:   The count register has no reset and keeps its value.
`timescale 1ns/1ps
// Function
// - Clock source select cleared counts instruction cycles.
// - Timer mode without prescaler adds one every instruction cycle.
// - A count register write stops counting for two instruction cycles.
// - Clock source select set counts external input edges.
// - Edge select cleared counts rising edges, set counts falling.
// - Prescaler serves timer or watchdog, chosen by assignment bit.
// - Prescaler count is never readable or writable.
// - Timer prescale ratios run from 1:2 up to 1:256.
// - Rate codes 000..111 give timer 1:2..1:256, watchdog 1:1..1:128.
// - Prescaler output is sampled on second and fourth phase clocks.
// - Prescaler divides symmetrically; source period bound by ratio.
// - External change reaches the count in three to seven periods.
// - Count register at address 01h, read/write, no reset value.
// - Counter mode overrides the direction bit of port C bit five.
// - Configuration is write-only, loaded by instruction, reset to ones.
module t0ps_timer
	import t0ps_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk_sys_i,
	input  wire logic       resetn_i,
	// Data register access.
	input  wire logic [6:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic      [7:0] reg_rdata_o,
	// Dedicated register loads from the working register.
	input  wire logic       cfg_load_i,
	input  wire logic       dir_load_i,
	input  wire logic [7:0] w_data_i,
	// External count input and port C drivers.
	input  wire logic       external_count_input_i,
	output logic      [5:0] port_c_oe_o,
	// Watchdog timer side.
	input  wire logic       watchdog_tick_i,
	output logic            watchdog_tick_o
);

	logic [7:0] timer_config_q;
	logic [5:0] port_c_direction_q;
	logic [7:0] timer_count_value_q;
	logic [1:0] phase_q;
	logic [1:0] inhibit_q;
	logic       src_prev_q;
	logic       samp1_q;
	logic       samp2_q;
	logic       strobe_d_q;
	logic       ext_inc_q;
	logic       tdiv_prev_q;
	logic       wdiv_prev_q;
	logic       wdt_tick_q;
	logic [7:0] rdata_q;

	logic       clock_source_select;
	logic       source_edge_select;
	logic       prescaler_assign;
	logic [2:0] prescale_rate_select;
	logic       to_timer;
	logic       cycle_end;
	logic       second_phase_clock;
	logic       fourth_phase_clock;
	logic       sample_strobe;
	logic       ext_src;
	logic       ext_rise;
	logic       presc_tick;
	logic       presc_clr;
	logic       div_timer;
	logic       div_wdt;
	logic       sync_in;
	logic       tmr_inc;
	logic       inc;
	logic       count_wr;

	assign clock_source_select  = timer_config_q[CS_BIT];
	assign source_edge_select   = timer_config_q[EDGE_BIT];
	assign prescaler_assign     = timer_config_q[PSA_BIT];
	assign prescale_rate_select = timer_config_q[RATE_MSB:RATE_LSB];
	assign to_timer             = !prescaler_assign;
	assign count_wr             = reg_wr_i && (reg_addr_i == COUNT_ADDR);

	// Write-only registers, set to all ones by reset.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			timer_config_q <= CFG_RST;
		end else if (cfg_load_i) begin
			timer_config_q <= w_data_i;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			port_c_direction_q <= DIR_RST;
		end else if (dir_load_i) begin
			port_c_direction_q <= w_data_i[5:0];
		end
	end

	// Counter mode takes the pin away from its direction bit.
	always_comb begin
		port_c_oe_o           = ~port_c_direction_q;
		port_c_oe_o[PIN5_BIT] = !port_c_direction_q[PIN5_BIT]
		                        && !clock_source_select;
	end

	// Four oscillator periods form one instruction cycle.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			phase_q <= PH_Q1;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end

	assign second_phase_clock = (phase_q == PH_Q2);
	assign fourth_phase_clock = (phase_q == PH_Q4);
	assign cycle_end          = fourth_phase_clock;
	assign sample_strobe      = second_phase_clock || fourth_phase_clock;

	// Inverting the pin turns a falling edge into a rising one.
	assign ext_src  = external_count_input_i ^ source_edge_select;
	assign ext_rise = ext_src && !src_prev_q;

	// Edge history resets high, so reset alone never looks like an edge.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			src_prev_q <= 1'b1;
		end else begin
			src_prev_q <= ext_src;
		end
	end

	// The prescaler follows whichever party owns it.
	always_comb begin
		if (!to_timer) begin
			presc_tick = watchdog_tick_i;
		end else if (clock_source_select) begin
			presc_tick = ext_rise;
		end else begin
			presc_tick = cycle_end;
		end
	end

	assign presc_clr = cfg_load_i || (count_wr && to_timer);

	t0ps_presc u_presc (
		.clk_sys_i   (clk_sys_i),
		.resetn_i    (resetn_i),
		.clr_i       (presc_clr),
		.tick_i      (presc_tick),
		.rate_i      (prescale_rate_select),
		.div_timer_o (div_timer),
		.div_wdt_o   (div_wdt)
	);

	// Without a prescaler the raw input is the prescaler output.
	assign sync_in = to_timer ? div_timer : ext_src;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			samp1_q    <= 1'b1;
			samp2_q    <= 1'b1;
			strobe_d_q <= 1'b0;
			ext_inc_q  <= 1'b0;
		end else begin
			if (sample_strobe) begin
				samp1_q <= sync_in;
				samp2_q <= samp1_q;
			end
			strobe_d_q <= sample_strobe;
			ext_inc_q  <= strobe_d_q && samp1_q && !samp2_q;
		end
	end

	// Timer mode with prescaler counts rises of the divided level.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tdiv_prev_q <= 1'b0;
			wdiv_prev_q <= 1'b0;
			wdt_tick_q  <= 1'b0;
		end else begin
			tdiv_prev_q <= div_timer;
			wdiv_prev_q <= div_wdt;
			if (!prescaler_assign) begin
				wdt_tick_q <= 1'b0;
			end else if (prescale_rate_select == 3'h0) begin
				wdt_tick_q <= watchdog_tick_i;
			end else begin
				wdt_tick_q <= div_wdt && !wdiv_prev_q;
			end
		end
	end

	assign watchdog_tick_o = wdt_tick_q;
	assign tmr_inc = to_timer ? (div_timer && !tdiv_prev_q) : cycle_end;
	assign inc     = clock_source_select ? ext_inc_q
	                 : tmr_inc;

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			inhibit_q <= 2'h0;
		end else if (count_wr) begin
			inhibit_q <= INHIBIT_CYC;
		end else if (cycle_end && inhibit_q != 2'h0) begin
			inhibit_q <= inhibit_q - 2'h1;
		end
	end

	// The count keeps its value through reset.
	always_ff @(posedge clk_sys_i) begin
		if (count_wr) begin
			timer_count_value_q <= reg_wdata_i;
		end else if (inc && inhibit_q == 2'h0) begin
			timer_count_value_q <= timer_count_value_q + 8'h01;
		end
	end

	// Only the count register is mapped; the prescaler is not.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_q <= RDATA_RST;
		end else if (reg_addr_i == COUNT_ADDR) begin
			rdata_q <= timer_count_value_q;
		end else begin
			rdata_q <= RDATA_RST;
		end
	end

	assign reg_rdata_o = rdata_q;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);

	chk_timer_incr: assert property (
		!clock_source_select && !to_timer && cycle_end && !count_wr
		&& inhibit_q == 2'h0
		|=> timer_count_value_q
		== 8'($past(timer_count_value_q) + 8'h01))
		else $error("timer mode missed an instruction cycle increment");

	chk_wr_inhibit: assert property (
		count_wr ##1 (!count_wr)[*7]
		|-> timer_count_value_q == $past(reg_wdata_i, 7))
		else $error("count moved within two cycles after a write");

	chk_ext_latency: assert property (
		clock_source_select && !to_timer && ext_rise && !cfg_load_i
		&& !$past(ext_src, 2) ##1 (ext_src && !cfg_load_i)
		|-> ##[1:2] ext_inc_q)
		else $error("external edge not counted within seven periods");

	chk_ext_only: assert property (
		clock_source_select && !count_wr && inhibit_q == 2'h0
		&& !ext_inc_q |=> timer_count_value_q
		=== $past(timer_count_value_q))
		else $error("counter mode advanced without an external edge");

	chk_presc_excl: assert property (
		watchdog_tick_o |-> $past(prescaler_assign))
		else $error("watchdog tick while prescaler owned by timer");

	chk_wdt_ratio: assert property (
		prescaler_assign && prescale_rate_select == 3'h0
		&& !cfg_load_i && watchdog_tick_i |=> watchdog_tick_o)
		else $error("watchdog 1:1 ratio did not pass the tick");

	chk_sample_phase: assert property (
		$changed(samp1_q) |-> $past(sample_strobe))
		else $error("sampling outside second or fourth phase");

	chk_pin_priority: assert property (
		clock_source_select |-> !port_c_oe_o[PIN5_BIT])
		else $error("pin driven while used as count input");

	chk_cfg_reset: assert property (
		!$past(resetn_i) |-> timer_config_q == CFG_RST
		&& port_c_direction_q == DIR_RST)
		else $error("configuration not all ones after reset");

	chk_read_count: assert property (
		reg_addr_i == COUNT_ADDR |=> reg_rdata_o
		=== $past(timer_count_value_q))
		else $error("count register read returned wrong value");

	cov_wrap: cover property (
		timer_count_value_q == 8'hFF ##1 timer_count_value_q == 8'h00);
	cov_ext_inc: cover property (clock_source_select && ext_inc_q);
	cov_wdt_tick: cover property (watchdog_tick_o);
	cov_inhibit: cover property (count_wr ##1 inhibit_q == INHIBIT_CYC);

endmodule

/* File: inc/t0ps_pkg.sv */
// Purpose: Shared constants for the timer/counter with shared prescaler.
// Assumes: One system clock tick equals one oscillator period (Tosc).
// Notes:   Four oscillator periods make one instruction cycle.
package t0ps_pkg;

	// Count register data address, configuration field positions and the port C pin bit.
	localparam logic [6:0] COUNT_ADDR   = 7'h01;
	localparam int         CS_BIT       = 5;
	localparam int         EDGE_BIT     = 4;
	localparam int         PSA_BIT      = 3;
	localparam int         RATE_MSB     = 2;
	localparam int         RATE_LSB     = 0;
	localparam int         PIN5_BIT     = 5;

	// Reset values of the write-only registers and of the read data.
	localparam logic [7:0] CFG_RST      = 8'hFF;
	localparam logic [5:0] DIR_RST      = 6'h3F;
	localparam logic [7:0] RDATA_RST    = 8'h00;

	// Phase counter: Q1 is phase 0, Q4 is phase 3.
	localparam logic [1:0] PH_Q1        = 2'h0;
	localparam logic [1:0] PH_Q2        = 2'h1;
	localparam logic [1:0] PH_Q4        = 2'h3;

	// Cycles in which counting stops after a count register write.
	localparam logic [1:0] INHIBIT_CYC  = 2'h2;

	// Timing figures in picoseconds, oscillator periods and clocks; one period is one clock.
	localparam int         CLK_PS       = 8000;
	localparam int         TOSC_PS      = 8000;
	localparam int         LAT_MIN_TOSC = 3;
	localparam int         LAT_MAX_TOSC = 7;
	localparam int         LAT_MIN_CYC  = (LAT_MIN_TOSC * TOSC_PS
	                                       + CLK_PS - 1) / CLK_PS;
	localparam int         LAT_MAX_CYC  = (LAT_MAX_TOSC * TOSC_PS) / CLK_PS;

endpackage
